// [gps_pkg.sv]
// Constants shared by the port logic: offsets, fields, reset values and pin roles
package gps_pkg;
  localparam int PA_W = 8;
  localparam int PB_W = 2;
  localparam int ADDR_W = 6;
  // Register byte offsets
  localparam logic [5:0] OFF_PA_DATA = 6'h00;
  localparam logic [5:0] OFF_PA_DIR = 6'h04;
  localparam logic [5:0] OFF_PA_PULL = 6'h08;
  localparam logic [5:0] OFF_PA_WAKE = 6'h0c;
  localparam logic [5:0] OFF_PB_DATA = 6'h10;
  localparam logic [5:0] OFF_PB_DIR = 6'h14;
  localparam logic [5:0] OFF_PB_PULL = 6'h18;
  localparam logic [5:0] OFF_FN_CTRL = 6'h1c;
  localparam logic [5:0] OFF_ANA_SEL = 6'h20;
  localparam logic [5:0] OFF_BIT_OP = 6'h24;
  localparam logic [5:0] OFF_STATUS = 6'h28;
  // Reset values
  localparam logic [7:0] RST_PA_LATCH = 8'hff;
  localparam logic [7:0] RST_PA_DIR = 8'hff;
  localparam logic [7:0] RST_PA_PULL = 8'h00;
  localparam logic [7:0] RST_PA_WAKE = 8'h00;
  localparam logic [1:0] RST_PB_LATCH = 2'h3;
  localparam logic [1:0] RST_PB_DIR = 2'h3;
  localparam logic [1:0] RST_PB_PULL = 2'h0;
  localparam logic [1:0] RST_FN_CTRL = 2'h0;
  localparam logic [1:0] RST_ANA_SEL = 2'h0;
  // Pull-up positions that exist on port A (pin 7 has none)
  localparam logic [7:0] PA_PULL_MASK = 8'h7f;
  // Output function control fields
  localparam int FN_DIV_BIT = 0;
  localparam int FN_PWM_BIT = 1;
  // Bit operation fields
  localparam int BOP_IDX_LSB = 0;
  localparam int BOP_PORTB_BIT = 3;
  localparam int BOP_DIR_BIT = 4;
  localparam int BOP_VAL_BIT = 5;
  // Status fields
  localparam int ST_WAKE_BIT = 0;
  // Shared pin positions on port A
  localparam int PIN_DIV = 1;
  localparam int PIN_PWM = 2;
  localparam int PIN_INT = 3;
  localparam int PIN_TMR0 = 4;
  localparam int PIN_TMR1 = 5;
endpackage : gps_pkg

// [gps_pad_if.sv]
// Interface between the register logic and the pad cells of one port
interface gps_pad_if #(parameter int W = 8);
  logic [W-1:0] dir;
  logic [W-1:0] latch;
  logic [W-1:0] altEn;
  logic [W-1:0] altVal;
  logic [W-1:0] pullEn;
  logic [W-1:0] anaSel;
  logic [W-1:0] pinIn;
  logic [W-1:0] readVal;
  logic [W-1:0] pinOut;
  logic [W-1:0] pinOe;
  logic [W-1:0] pullOn;
  modport ctrl (output dir, latch, altEn, altVal, pullEn, anaSel, pinIn,
                input readVal, pinOut, pinOe, pullOn);
  modport pad (input dir, latch, altEn, altVal, pullEn, anaSel, pinIn,
               output readVal, pinOut, pinOe, pullOn);
endinterface : gps_pad_if

// [gps_port_pad.sv]
// Pad cells of one port: drive, read-back and pull-up per pin
module gps_port_pad #(
  parameter int W = 8
) (
  gps_pad_if.pad p
);
  if (W < 1 || W > 8)
  begin : g_chk
    $error("gps_port_pad: width must be 1 to 8");
  end
  for (genvar i = 0; i < W; i++)
  begin : g_pin
    // Direction 1 is input, 0 is push-pull output
    assign p.pinOe[i] = ~p.dir[i];
    assign p.pinOut[i] = p.altEn[i] ? p.altVal[i] : p.latch[i];
    // Input reads the pin, output reads the latch
    assign p.readVal[i] = p.dir[i] ? p.pinIn[i] : p.latch[i];
    // Pull-up only on inputs, never on analog pins
    assign p.pullOn[i] = p.pullEn[i] & p.dir[i] & ~p.anaSel[i];
  end
endmodule : gps_port_pad

// [gps_gpio_port.sv]
// Two-port general-purpose I/O block with pin sharing and Avalon-MM registers
//
// The implementer's own choices: the Avalon-MM register port and the register offsets.
module gps_gpio_port
  import gps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [PA_W-1:0] paIn,
  output logic [PA_W-1:0] paOut,
  output logic [PA_W-1:0] paOe,
  output logic [PA_W-1:0] paPullup,
  input wire logic [PB_W-1:0] pbIn,
  output logic [PB_W-1:0] pbOut,
  output logic [PB_W-1:0] pbOe,
  output logic [PB_W-1:0] pbPullup,
  input wire logic freqDividerIn,
  input wire logic pwmIn,
  output logic [PB_W-1:0] analogPinSelect,
  output logic extIntIn,
  output logic timer0EventPin,
  output logic timer1EventPin,
  input wire logic sleepMode,
  output logic wakeReq
);

  gps_pad_if #(.W(PA_W)) padA ();
  gps_pad_if #(.W(PB_W)) padB ();

  logic [7:0] latchA;
  logic [7:0] dirA;
  logic [7:0] pullA;
  logic [7:0] wakeEnA;
  logic [1:0] latchB;
  logic [1:0] dirB;
  logic [1:0] pullB;
  logic [1:0] fnCtrl;
  logic [1:0] anaSel;
  logic wakeFlag;
  logic ack;
  logic [7:0] prevA;
  logic [7:0] next_latchA;
  logic [7:0] next_dirA;
  logic [7:0] next_pullA;
  logic [7:0] next_wakeEnA;
  logic [1:0] next_latchB;
  logic [1:0] next_dirB;
  logic [1:0] next_pullB;
  logic [1:0] next_fnCtrl;
  logic [1:0] next_anaSel;
  logic next_wakeFlag;
  logic next_ack;
  logic [31:0] next_readdata;
  logic [7:0] rdByte;
  logic [7:0] rmwA;
  logic [1:0] rmwB;
  logic [7:0] fallA;
  logic req;
  logic wrTake;
  logic [7:0] wd;

  // Pad cells
  gps_port_pad #(.W(PA_W)) u_padA (.p(padA.pad));
  gps_port_pad #(.W(PB_W)) u_padB (.p(padB.pad));

  always_comb
  begin
    padA.dir = dirA;
    padA.latch = latchA;
    padA.altEn = '0;
    padA.altEn[PIN_DIV] = fnCtrl[FN_DIV_BIT];
    padA.altEn[PIN_PWM] = fnCtrl[FN_PWM_BIT];
    padA.altVal = '0;
    padA.altVal[PIN_DIV] = freqDividerIn;
    padA.altVal[PIN_PWM] = pwmIn;
    padA.pullEn = pullA;
    padA.anaSel = '0;
    padA.pinIn = paIn;
    padB.dir = dirB;
    padB.latch = latchB;
    padB.altEn = '0;
    padB.altVal = '0;
    padB.pullEn = pullB;
    padB.anaSel = anaSel;
    padB.pinIn = pbIn;
  end

  assign paOut = padA.pinOut;
  assign paOe = padA.pinOe;
  assign paPullup = padA.pullOn;
  assign pbOut = padB.pinOut;
  assign pbOe = padB.pinOe;
  assign pbPullup = padB.pullOn;
  assign analogPinSelect = anaSel;

  // Shared inputs seen by interrupt and timers; port read unaffected
  assign extIntIn = paIn[PIN_INT];
  assign timer0EventPin = paIn[PIN_TMR0];
  assign timer1EventPin = paIn[PIN_TMR1];

  // Falling edges on wake-enabled pins while asleep
  assign fallA = prevA & ~paIn & wakeEnA;
  assign wakeReq = sleepMode & (|fallA);

  // Bus handshake: one wait cycle, then the answer
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack;
  assign wrTake = avs_write & ack & avs_byteenable[0];
  assign wd = avs_writedata[7:0];

  always_comb
  begin
    unique case (avs_address)
      OFF_PA_DATA: rdByte = padA.readVal;
      OFF_PA_DIR: rdByte = dirA;
      OFF_PA_PULL: rdByte = pullA & PA_PULL_MASK;
      OFF_PA_WAKE: rdByte = wakeEnA;
      OFF_PB_DATA: rdByte = {6'h00, padB.readVal};
      OFF_PB_DIR: rdByte = {6'h00, dirB};
      OFF_PB_PULL: rdByte = {6'h00, pullB};
      OFF_FN_CTRL: rdByte = {6'h00, fnCtrl};
      OFF_ANA_SEL: rdByte = {6'h00, anaSel};
      OFF_STATUS: rdByte = {7'h00, wakeFlag};
      default: rdByte = 8'h00;
    endcase
  end

  // Read-modify-write images of the whole port
  always_comb
  begin
    rmwA = wd[BOP_DIR_BIT] ? dirA : padA.readVal;
    rmwA[wd[BOP_IDX_LSB +: 3]] = wd[BOP_VAL_BIT];
    rmwB = wd[BOP_DIR_BIT] ? dirB : padB.readVal;
    if (wd[BOP_IDX_LSB + 1 +: 2] == 2'h0)
    begin
      rmwB[wd[BOP_IDX_LSB]] = wd[BOP_VAL_BIT];
    end
  end

  always_comb
  begin
    next_latchA = latchA;
    next_dirA = dirA;
    next_pullA = pullA;
    next_wakeEnA = wakeEnA;
    next_latchB = latchB;
    next_dirB = dirB;
    next_pullB = pullB;
    next_fnCtrl = fnCtrl;
    next_anaSel = anaSel;
    next_ack = req & ~ack;
    next_readdata = avs_readdata;
    if (avs_read && !ack)
    begin
      next_readdata = {24'h000000, rdByte};
    end
    if (wrTake)
    begin
      unique case (avs_address)
        OFF_PA_DATA: next_latchA = wd;
        OFF_PA_DIR: next_dirA = wd;
        OFF_PA_PULL: next_pullA = wd & PA_PULL_MASK;
        OFF_PA_WAKE: next_wakeEnA = wd;
        OFF_PB_DATA: next_latchB = wd[1:0];
        OFF_PB_DIR: next_dirB = wd[1:0];
        OFF_PB_PULL: next_pullB = wd[1:0];
        OFF_FN_CTRL: next_fnCtrl = wd[1:0];
        OFF_ANA_SEL: next_anaSel = wd[1:0];
        OFF_BIT_OP:
        begin
          if (wd[BOP_PORTB_BIT])
          begin
            if (wd[BOP_DIR_BIT])
            begin
              next_dirB = rmwB;
            end
            else
            begin
              next_latchB = rmwB;
            end
          end
          else if (wd[BOP_DIR_BIT])
          begin
            next_dirA = rmwA;
          end
          else
          begin
            next_latchA = rmwA;
          end
        end
        default: next_ack = next_ack;
      endcase
    end
    // Sticky wake flag, a new event beats the clear
    next_wakeFlag = wakeFlag;
    if (wrTake && avs_address == OFF_STATUS && wd[ST_WAKE_BIT])
    begin
      next_wakeFlag = 1'b0;
    end
    if (wakeReq)
    begin
      next_wakeFlag = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      latchA <= RST_PA_LATCH;
      dirA <= RST_PA_DIR;
      pullA <= RST_PA_PULL;
      wakeEnA <= RST_PA_WAKE;
      latchB <= RST_PB_LATCH;
      dirB <= RST_PB_DIR;
      pullB <= RST_PB_PULL;
      fnCtrl <= RST_FN_CTRL;
      anaSel <= RST_ANA_SEL;
      wakeFlag <= 1'b0;
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      prevA <= RST_PA_LATCH;
    end
    else
    begin
      latchA <= next_latchA;
      dirA <= next_dirA;
      pullA <= next_pullA;
      wakeEnA <= next_wakeEnA;
      latchB <= next_latchB;
      dirB <= next_dirB;
      pullB <= next_pullB;
      fnCtrl <= next_fnCtrl;
      anaSel <= next_anaSel;
      wakeFlag <= next_wakeFlag;
      ack <= next_ack;
      avs_readdata <= next_readdata;
      prevA <= paIn;
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);

  chk_dir_write_drive: assert property (
    (wrTake && avs_address == OFF_PA_DIR) |=> (paOe == ~$past(wd)))
    else $error("port A drive enables do not follow direction write");

  chk_read_pin_latch: assert property (
    (avs_read && !avs_waitrequest && avs_address == OFF_PA_DATA)
      |-> avs_readdata[7:0] == (($past(paIn) & $past(dirA)) | ($past(latchA) & ~$past(dirA))))
    else $error("port A read does not mix pin and latch by direction");

  chk_latch_to_pin: assert property (
    (wrTake && avs_address == OFF_PA_DATA && !fnCtrl[FN_DIV_BIT] && !fnCtrl[FN_PWM_BIT])
      |=> (paOut == $past(wd)))
    else $error("latch write not on pins after write cycle");

  chk_div_gated: assert property (
    !fnCtrl[FN_DIV_BIT] |-> paOut[PIN_DIV] == latchA[PIN_DIV])
    else $error("divider output on pin while not selected");

  chk_pwm_route: assert property (
    (fnCtrl[FN_PWM_BIT] && !dirA[PIN_PWM]) |-> (paOe[PIN_PWM] && paOut[PIN_PWM] == pwmIn))
    else $error("selected PWM not driven on output pin");

  chk_analog_pull: assert property (
    (pbPullup & anaSel) == 2'h0)
    else $error("pull-up on analog-selected pin");

  chk_pin7_pull: assert property (
    !paPullup[7] && !pullA[7])
    else $error("pin 7 pull-up present");

  chk_reset_state: assert property (
    $rose(nrst) |-> (latchA == 8'hff && dirA == 8'hff && dirB == 2'h3 && wakeEnA == 8'h00))
    else $error("port state after reset wrong");

  chk_wake_fall: assert property (
    (sleepMode && |(wakeEnA & $past(paIn) & ~paIn)) |-> wakeReq ##1 wakeFlag)
    else $error("enabled falling edge did not wake");

  chk_bit_set: assert property (
    (wrTake && avs_address == OFF_BIT_OP && !wd[BOP_PORTB_BIT] && !wd[BOP_DIR_BIT])
      |=> latchA[$past(wd[2:0])] == $past(wd[BOP_VAL_BIT]))
    else $error("bit operation did not update addressed latch bit");

  chk_div_on_output: assert property (
    (fnCtrl[FN_DIV_BIT] && !dirA[PIN_DIV]) |-> (paOe[PIN_DIV] && paOut[PIN_DIV] == freqDividerIn))
    else $error("selected divider not driven on output pin");

  chk_div_as_input: assert property (
    dirA[PIN_DIV] |-> (!paOe[PIN_DIV] && paPullup[PIN_DIV] == pullA[PIN_DIV]))
    else $error("divider pin set as input is not a plain input");

  chk_pwm_as_input: assert property (
    dirA[PIN_PWM] |-> (!paOe[PIN_PWM] && paPullup[PIN_PWM] == pullA[PIN_PWM]))
    else $error("PWM pin set as input is not a plain input");

  chk_shared_pull: assert property (
    paPullup == (pullA & dirA & PA_PULL_MASK))
    else $error("port A pull-ups do not follow enable and direction");

  chk_event_taps: assert property (
    extIntIn == paIn[PIN_INT] && timer0EventPin == paIn[PIN_TMR0] && timer1EventPin == paIn[PIN_TMR1])
    else $error("shared input taps do not follow the pins");

  chk_unset_latch_high: assert property (
    (wrTake && avs_address == OFF_PA_DIR && latchA == RST_PA_LATCH && fnCtrl == RST_FN_CTRL)
      |=> ((paOut & paOe) == paOe))
    else $error("new output pin not driven high from reset latch");

  chk_wake_gate: assert property (
    (!sleepMode || wakeEnA == RST_PA_WAKE) |-> !wakeReq)
    else $error("wake request while awake or not enabled");

  chk_flag_set_wins: assert property (
    wakeReq |=> wakeFlag)
    else $error("wake flag not set after wake request");

endmodule : gps_gpio_port

// [gps_board.sv]
// Board model: resolves pin levels from drivers, pull-ups and outside sources
module gps_board #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic [W-1:0] drvOut,
  input wire logic [W-1:0] drvOe,
  input wire logic [W-1:0] pullOn,
  input wire logic [W-1:0] extVal,
  input wire logic [W-1:0] extOe,
  output logic [W-1:0] pinLvl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] flt = '0;
  // Undriven pins without pull-up wander
  always @(posedge sys_clk)
    flt <= ~flt;
  always_comb
    for (int i = 0; i < W; i++)
      pinLvl[i] = drvOe[i] ? drvOut[i] : extOe[i] ? extVal[i] : pullOn[i] ? 1'b1 : flt[i];
endmodule : gps_board

// [tb.sv]
// Testbench for the port block with board models on both ports
module tb
  import gps_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, nrst = 0, rd = 0, wr = 0, wreq, fdIn = 0, pwmIn = 0, sleep = 0;
  logic intP, t0, t1, wake;
  logic [5:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic [7:0] paIn, paOut, paOe, port_a_pullup_enable, extA = '0, extAOe = '0;
  logic [1:0] pbIn, pbOut, pbOe, pbPu, ana, extB = '0, extBOe = '0;
  int errorCnt = 0, totalChecks = 0;

  gps_gpio_port dut (.sys_clk(sys_clk), .nrst(nrst), .avs_address(addr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wdata), .avs_byteenable(4'h1), .avs_readdata(rdata),
    .avs_waitrequest(wreq), .paIn(paIn), .paOut(paOut), .paOe(paOe), .paPullup(port_a_pullup_enable),
    .pbIn(pbIn), .pbOut(pbOut), .pbOe(pbOe), .pbPullup(pbPu), .freqDividerIn(fdIn),
    .pwmIn(pwmIn), .analogPinSelect(ana), .extIntIn(intP), .timer0EventPin(t0),
    .timer1EventPin(t1), .sleepMode(sleep), .wakeReq(wake));
  gps_board #(.W(8)) brdA (.sys_clk(sys_clk), .drvOut(paOut), .drvOe(paOe), .pullOn(port_a_pullup_enable),
    .extVal(extA), .extOe(extAOe), .pinLvl(paIn));
  gps_board #(.W(2)) brdB (.sys_clk(sys_clk), .drvOut(pbOut), .drvOe(pbOe), .pullOn(pbPu),
    .extVal(extB), .extOe(extBOe), .pinLvl(pbIn));

  initial
    forever #2.5 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask : chk

  task automatic bus(input logic isWr, input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= {24'h0, d};
    rd <= ~isWr;
    wr <= isWr;
    // Hold until the edge that sees waitrequest low
    do
      @(posedge sys_clk);
    while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(negedge sys_clk);
  endtask : bus

  task automatic endSim;
    $display("checks %0d mismatches %0d", totalChecks, errorCnt);
    if (errorCnt == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : endSim

  task automatic t_reset;
    logic [5:0] offs[7];
    logic [7:0] exps[7];
    offs = '{OFF_PA_DIR, OFF_PA_PULL, OFF_PA_WAKE, OFF_PB_DIR, OFF_PB_PULL, OFF_ANA_SEL, 6'h30};
    exps = '{8'hff, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00};
    chk("paOe", paOe, 0);
    chk("paOut", paOut, 8'hff);
    bus(1, 6'h30, 8'h5a);
    foreach (offs[i])
    begin
      bus(0, offs[i], 0);
      chk("rst", q, exps[i]);
    end
    $display("test reset done");
  endtask : t_reset

  task automatic t_dir;
    @(posedge sys_clk);
    extAOe <= 8'hf0;
    extA <= 8'ha0;
    bus(1, OFF_PA_DIR, 8'hf0);
    chk("paOe", paOe, 8'h0f);
    chk("paOutLo", paOut[3:0], 4'hf);
    bus(0, OFF_PA_DATA, 0);
    chk("paRd", q, 8'haf);
    bus(1, OFF_PA_DATA, 8'h05);
    chk("paOutLo", paOut[3:0], 4'h5);
    bus(0, OFF_PA_DATA, 0);
    chk("paRd", q, 8'ha5);
    $display("test direction done");
  endtask : t_dir

  task automatic t_share;
    @(posedge sys_clk);
    extAOe <= 8'hf8;
    extA <= 8'h28;
    bus(1, OFF_PA_DIR, 8'hf8);
    bus(1, OFF_PA_PULL, 8'hff);
    bus(0, OFF_PA_PULL, 0);
    chk("pullRd", q, 8'h7f);
    chk("port_a_pullup_enable", port_a_pullup_enable, 8'h78);
    chk("evt", {t1, t0, intP}, 3'b101);
    bus(0, OFF_PA_DATA, 0);
    chk("paRd", q[7:3], 5'b00101);
    @(posedge sys_clk);
    extA <= 8'h10;
    @(negedge sys_clk);
    chk("evt", {t1, t0, intP}, 3'b010);
    $display("test shared inputs done");
  endtask : t_share

  task automatic t_alt;
    chk("latch", paOut[2:1], 2'b10);
    bus(1, OFF_FN_CTRL, 8'h03);
    for (int v = 0; v < 2; v++)
    begin
      @(posedge sys_clk);
      fdIn <= v[0];
      pwmIn <= ~v[0];
      @(negedge sys_clk);
      chk("alt", paOut[2:1], {~v[0], v[0]});
    end
    @(posedge sys_clk);
    fdIn <= 1'b0;
    pwmIn <= 1'b0;
    bus(1, OFF_PA_DIR, 8'hfe);
    chk("altOe", paOe[2:1], 2'b00);
    chk("altPu", port_a_pullup_enable[2:1], 2'b11);
    bus(0, OFF_PA_DATA, 0);
    chk("altRd", q[2:1], 2'b11);
    bus(1, OFF_FN_CTRL, 8'h01);
    bus(1, OFF_PA_DIR, 8'hf8);
    chk("pwmOff", paOut[2], 1'b1);
    $display("test alternate outputs done");
  endtask : t_alt

  task automatic t_portb;
    bus(1, OFF_PB_PULL, 8'h03);
    chk("pbPu", pbPu, 2'b11);
    bus(1, OFF_ANA_SEL, 8'h01);
    chk("ana", ana, 2'b01);
    chk("pbPu", pbPu, 2'b10);
    bus(0, OFF_ANA_SEL, 0);
    chk("anaRd", q, 1);
    bus(1, OFF_PB_DIR, 8'h00);
    chk("pbDrv", {pbOe, pbOut}, 4'hf);
    bus(1, OFF_BIT_OP, 8'h08);
    chk("pbRmw", pbOut, 2'b10);
    bus(0, OFF_PB_DATA, 0);
    chk("pbRd", q, 2);
    bus(1, OFF_BIT_OP, 8'h39);
    chk("pbRmwDir", {pbOe, pbPu}, 4'b0110);
    $display("test port b done");
  endtask : t_portb

  task automatic t_bitop;
    bus(1, OFF_FN_CTRL, 8'h00);
    @(posedge sys_clk);
    extA <= 8'hc8;
    bus(1, OFF_PA_DATA, 8'h00);
    bus(1, OFF_BIT_OP, 8'h20);
    chk("rmwData", paOut, 8'hc9);
    @(posedge sys_clk);
    extAOe <= 8'h78;
    bus(1, OFF_BIT_OP, 8'h17);
    chk("rmwDir", paOe, 8'h87);
    chk("pin7", paOut[7], 1'b1);
    bus(0, OFF_BIT_OP, 0);
    chk("bopRd", q, 0);
    $display("test bit operation done");
  endtask : t_bitop

  task automatic t_wake;
    bus(1, OFF_PA_WAKE, 8'h01);
    bus(0, OFF_PA_WAKE, 0);
    chk("wakeRd", q, 1);
    @(posedge sys_clk);
    extAOe <= 8'h79;
    extA <= 8'h01;
    sleep <= 1'b1;
    bus(1, OFF_PA_DIR, 8'hf9);
    @(posedge sys_clk);
    extA <= 8'h00;
    @(negedge sys_clk);
    chk("wake", wake, 1);
    @(negedge sys_clk);
    chk("wake", wake, 0);
    bus(0, OFF_STATUS, 0);
    chk("flag", q, 1);
    bus(1, OFF_STATUS, 8'h01);
    bus(1, OFF_PA_WAKE, 8'h00);
    @(posedge sys_clk);
    extA <= 8'h01;
    @(posedge sys_clk);
    extA <= 8'h00;
    @(negedge sys_clk);
    chk("noWake", wake, 0);
    bus(0, OFF_STATUS, 0);
    chk("flag", q, 0);
    bus(1, OFF_PA_WAKE, 8'h01);
    @(posedge sys_clk);
    sleep <= 1'b0;
    extA <= 8'h01;
    @(posedge sys_clk);
    extA <= 8'h00;
    @(negedge sys_clk);
    chk("awake", wake, 0);
    $display("test wake done");
  endtask : t_wake

  task automatic t_rerst;
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk("rePaOe", paOe, 0);
    chk("rePaOut", paOut, 8'hff);
    chk("rePb", {pbOe, pbOut, pbPu}, 6'h0c);
    chk("rePu", port_a_pullup_enable, 0);
    bus(0, OFF_PA_WAKE, 0);
    chk("reWake", q, 0);
    $display("test mid-run reset done");
  endtask : t_rerst

  initial
  begin
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    t_reset();
    t_dir();
    t_share();
    t_alt();
    t_portb();
    t_bitop();
    t_wake();
    t_rerst();
    endSim();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errorCnt++;
    endSim();
  end
endmodule : tb
